/* File: prc_pkg.sv */
// Shared constants for the reset, power-down and host clock control block
package prc_pkg;
   localparam int CLK_MHZ = 125;
   localparam int PG_LOW_US = 100;
   localparam int PG_LOW_CYC = PG_LOW_US * CLK_MHZ;
   localparam int PCO_MAX_US = 350;
   localparam int PCO_MAX_CYC = PCO_MAX_US * CLK_MHZ;
   localparam int CLK_START_US = 20;
   localparam int CLK_START_CYC = CLK_START_US * CLK_MHZ;
   localparam int CNT_W = 16;
   localparam logic [1:0] CLK_HALF_DIV = 2'h2;
   localparam int NPORT = 2;
   // Received amplitude codes in mV peak to peak
   localparam logic [7:0] IDLE_ENTER_MV = 8'h41;
   localparam logic [7:0] IDLE_EXIT_MV = 8'hC8;
   localparam logic [3:0] IDLE_HOLD_CYC = 4'h8;
   localparam logic [1:0] SPD_10 = 2'h0;
   localparam logic [1:0] SPD_100 = 2'h1;
   localparam logic [1:0] SPD_1000 = 2'h2;
   // Host register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_AMP = 8'h08;
   localparam int CTRL_PG = 0;
   localparam int CTRL_RST_N = 1;
   localparam int CTRL_SLEEP = 2;
   localparam int CTRL_PD = 3;
   localparam logic [3:0] CTRL_RESET_VAL = 4'h0;
   localparam logic [7:0] AMP_RESET_VAL = 8'hFF;
   typedef enum logic [1:0] {PRC_OFF, PRC_RESET, PRC_SLEEP, PRC_ACTIVE} prc_mode_t;
endpackage

/* File: prc_if.sv */
// Control and serial-link status signals between host hub and PHY
`timescale 1ns/1ps
`default_nettype none
interface prc_if;
   logic supply_good_input;
   logic chip_reset_input_n;
   logic chip_sleep_input;
   logic link_pd_ind;
   logic [7:0] link_rx_amp;
   logic host_clock_output;
   modport device (
      input supply_good_input,
      input chip_reset_input_n,
      input chip_sleep_input,
      input link_pd_ind,
      input link_rx_amp,
      output host_clock_output
   );
   modport host (
      output supply_good_input,
      output chip_reset_input_n,
      output chip_sleep_input,
      output link_pd_ind,
      output link_rx_amp,
      input host_clock_output
   );
endinterface
`default_nettype wire

/* File: prc_sync.sv */
// Two-stage synchroniser for a group of level signals
`timescale 1ns/1ps
`default_nettype none
module prc_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   // First stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // prc_sync
`default_nettype wire

/* File: prc_device.sv */
// PHY side: power state, reset, host clock, port power and speed control
`timescale 1ns/1ps
`default_nettype none
module prc_device (
   input wire logic core_clk,
   input wire logic rst,
   prc_if.device lnk,
   input wire logic [prc_pkg::NPORT-1:0] port_disable,
   input wire logic [prc_pkg::NPORT-1:0] phy_pd_bit,
   input wire logic [prc_pkg::NPORT-1:0] link_required,
   input wire logic [prc_pkg::NPORT-1:0] link_up,
   input wire logic [prc_pkg::NPORT-1:0] energy_seen,
   input wire logic [prc_pkg::NPORT-1:0] force_en,
   input wire logic [2*prc_pkg::NPORT-1:0] force_speed,
   input wire logic [2*prc_pkg::NPORT-1:0] partner_speed,
   input wire logic low_power_state,
   input wire logic low_power_link_up,
   input wire logic an1000_disable,
   output logic chip_powered,
   output logic logic_reset,
   output logic chip_active,
   output logic link_idle,
   output logic tx_active,
   output logic [prc_pkg::NPORT-1:0] port_phy_en,
   output logic [prc_pkg::NPORT-1:0] port_link_en,
   output logic [prc_pkg::NPORT-1:0] energy_detect_mode,
   output logic [2*prc_pkg::NPORT-1:0] speed_sel
);
   // Whole block state in one word, registered in one place
   typedef struct packed {
      prc_pkg::prc_mode_t mode;
      logic [prc_pkg::CNT_W-1:0] clk_cnt;
      logic clk_on;
      logic [1:0] div;
      logic host_clk;
      logic [3:0] idle_cnt;
      logic idle;
      logic powered;
      logic in_reset;
      logic active;
      logic tx;
      logic [prc_pkg::NPORT-1:0] phy_en;
      logic [prc_pkg::NPORT-1:0] link_en;
      logic [prc_pkg::NPORT-1:0] ed_mode;
      logic [2*prc_pkg::NPORT-1:0] speed;
   } prc_dev_state_t;

   prc_dev_state_t st;
   prc_dev_state_t next_st;
   // Synchronised copies of the control pins
   logic [3:0] sync_q;
   logic pg_s;
   logic rst_n_s;
   logic sleep_s;
   logic pd_s;

   // Control pins arrive unrelated to our clock
   prc_sync #(.W(4)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .d({lnk.supply_good_input, lnk.chip_reset_input_n, lnk.chip_sleep_input,
          lnk.link_pd_ind}),
      .q(sync_q)
   );
   assign pg_s = sync_q[3];
   assign rst_n_s = sync_q[2];
   assign sleep_s = sync_q[1];
   assign pd_s = sync_q[0];

   // Next-state logic
   always_comb begin
      logic [1:0] spd;
      logic [1:0] cap;
      spd = prc_pkg::SPD_10;
      cap = prc_pkg::SPD_1000;
      next_st = st;
      // Mode from the three pins; supply good outranks the others
      if (!pg_s) begin
         next_st.mode = prc_pkg::PRC_OFF;
      end else if (!rst_n_s) begin
         next_st.mode = prc_pkg::PRC_RESET;
      end else if (sleep_s) begin
         next_st.mode = prc_pkg::PRC_SLEEP;
      end else begin
         next_st.mode = prc_pkg::PRC_ACTIVE;
      end
      // Reset and sleep need no start-up order, only the levels matter
      case (next_st.mode)
         prc_pkg::PRC_OFF: begin
            next_st.powered = 1'b0;
            next_st.in_reset = 1'b1;
            next_st.active = 1'b0;
         end
         prc_pkg::PRC_RESET: begin
            next_st.powered = 1'b1;
            next_st.in_reset = 1'b1;
            next_st.active = 1'b0;
         end
         prc_pkg::PRC_SLEEP: begin
            next_st.powered = 1'b1;
            next_st.in_reset = 1'b0;
            next_st.active = 1'b0;
         end
         prc_pkg::PRC_ACTIVE: begin
            next_st.powered = 1'b1;
            next_st.in_reset = 1'b0;
            next_st.active = 1'b1;
         end
         default: begin
            next_st.powered = 1'b0;
            next_st.in_reset = 1'b1;
            next_st.active = 1'b0;
         end
      endcase

      // Host clock: lock wait after supply good, well inside the limit
      // Counts on the synchronised level, so a pin glitch cannot
      // start the clock early
      if (!pg_s) begin
         next_st.clk_cnt = '0;
         next_st.clk_on = 1'b0;
      end else if (!st.clk_on) begin
         if (st.clk_cnt == prc_pkg::CNT_W'(prc_pkg::CLK_START_CYC - 1)) begin
            next_st.clk_on = 1'b1;
         end else begin
            next_st.clk_cnt = st.clk_cnt + 1'b1;
         end
      end

      // Divider enable toggles the clock; reset and sleep leave it running
      if (!st.clk_on) begin
         next_st.div = '0;
         next_st.host_clk = 1'b0;
      end else if (st.div == prc_pkg::CLK_HALF_DIV - 2'h1) begin
         next_st.div = '0;
         next_st.host_clk = ~st.host_clk;
      end else begin
         next_st.div = st.div + 2'h1;
      end

      // Idle detect with hysteresis; short dips are ignored
      // Amplitude bus is taken as steady in this clock domain
      if (!next_st.active) begin
         next_st.idle_cnt = '0;
         next_st.idle = 1'b1;
      end else if (lnk.link_rx_amp < prc_pkg::IDLE_ENTER_MV) begin
         if (st.idle_cnt == prc_pkg::IDLE_HOLD_CYC - 4'h1) begin
            next_st.idle = 1'b1;
         end else begin
            next_st.idle_cnt = st.idle_cnt + 4'h1;
         end
      end else begin
         next_st.idle_cnt = '0;
         if (lnk.link_rx_amp > prc_pkg::IDLE_EXIT_MV) begin
            next_st.idle = 1'b0;
         end
      end
      // Transmit quiet while idle or not active
      next_st.tx = next_st.active & ~next_st.idle & ~pd_s;
      // Per-port power and speed
      for (int p = 0; p < prc_pkg::NPORT; p++) begin
         logic run;
         run = next_st.active & ~port_disable[p] & ~phy_pd_bit[p] & ~pd_s;
         next_st.phy_en[p] = run;
         next_st.link_en[p] = next_st.active & ~port_disable[p];
         next_st.ed_mode[p] = run & link_required[p] & ~link_up[p] & ~energy_seen[p];
         // Gigabit barred by option or by a low power state
         cap = prc_pkg::SPD_1000;
         if (an1000_disable || low_power_state) begin
            cap = prc_pkg::SPD_100;
         end
         if (low_power_state && low_power_link_up) begin
            cap = prc_pkg::SPD_10;
         end
         if (force_en[p]) begin
            spd = force_speed[2*p +: 2];
         end else begin
            spd = partner_speed[2*p +: 2];
         end
         if (spd > cap) begin
            spd = cap;
         end
         // A stopped port reports the lowest speed
         next_st.speed[2*p +: 2] = run ? spd : prc_pkg::SPD_10;
      end
   end

   // State register
   // Reset lands off, in reset, with the link marked idle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st <= '{mode: prc_pkg::PRC_OFF, in_reset: 1'b1, idle: 1'b1, default: '0};
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state
   // Nothing after the flops, so no output can glitch
   assign lnk.host_clock_output = st.host_clk;
   assign chip_powered = st.powered;
   assign logic_reset = st.in_reset;
   assign chip_active = st.active;
   assign link_idle = st.idle;
   assign tx_active = st.tx;
   assign port_phy_en = st.phy_en;
   assign port_link_en = st.link_en;
   assign energy_detect_mode = st.ed_mode;
   assign speed_sel = st.speed;
endmodule // prc_device
`default_nettype wire

/* File: prc_host.sv */
// Hub side: APB-programmed supply good, reset, sleep and link drive
`timescale 1ns/1ps
`default_nettype none
module prc_host #(
   parameter int PG_LOW_CYC = prc_pkg::PG_LOW_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   prc_if.host lnk,
   input wire logic supply_ok,
   input wire logic osc_stable,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   typedef struct packed {
      logic [3:0] ctrl;
      logic [7:0] amp;
      logic pg;
      logic [prc_pkg::CNT_W-1:0] low_cnt;
      logic [prc_pkg::CNT_W-1:0] stab_cnt;
      logic clk_prev;
      logic clk_seen;
      logic [31:0] rdata;
      logic rdy;
      logic err;
   } prc_host_state_t;

   prc_host_state_t st;
   prc_host_state_t next_st;

   always_comb begin
      logic hit;
      logic low_ok;
      logic stab_ok;
      low_ok = 1'b0;
      stab_ok = 1'b0;
      next_st = st;
      hit = (paddr == prc_pkg::REG_CTRL) || (paddr == prc_pkg::REG_STATUS) ||
            (paddr == prc_pkg::REG_AMP);
      // Answer prepared in setup, so access completes with no wait
      next_st.rdy = psel & ~penable;
      next_st.err = psel & ~penable & ~hit;
      next_st.rdata = '0;
      if (psel && !penable) begin
         case (paddr)
            prc_pkg::REG_CTRL: next_st.rdata = {28'h0, st.ctrl};
            prc_pkg::REG_STATUS: next_st.rdata = {30'h0, st.clk_seen, st.pg};
            prc_pkg::REG_AMP: next_st.rdata = {24'h0, st.amp};
            default: next_st.rdata = '0;
         endcase
      end
      if (psel && penable && st.rdy && pwrite && !st.err) begin
         if (paddr == prc_pkg::REG_CTRL) begin
            next_st.ctrl = pwdata[3:0];
         end else if (paddr == prc_pkg::REG_AMP) begin
            next_st.amp = pwdata[7:0];
         end
      end
      // Low time and stable time, saturating
      low_ok = st.low_cnt >= prc_pkg::CNT_W'(PG_LOW_CYC);
      stab_ok = st.stab_cnt >= prc_pkg::CNT_W'(PG_LOW_CYC);
      if (st.pg) begin
         next_st.low_cnt = '0;
      end else if (!low_ok) begin
         next_st.low_cnt = st.low_cnt + 1'b1;
      end
      if (!(supply_ok && osc_stable)) begin
         next_st.stab_cnt = '0;
      end else if (!stab_ok) begin
         next_st.stab_cnt = st.stab_cnt + 1'b1;
      end
      if (!st.ctrl[prc_pkg::CTRL_PG] || !supply_ok || !osc_stable) begin
         next_st.pg = 1'b0;
      end else if (low_ok && stab_ok) begin
         next_st.pg = 1'b1;
      end
      // Clock seen once any edge shows; cleared with supply good
      next_st.clk_prev = lnk.host_clock_output;
      // An edge in the same cycle as the clear keeps the flag set
      if (lnk.host_clock_output != st.clk_prev) begin
         next_st.clk_seen = 1'b1;
      end else if (!st.pg) begin
         next_st.clk_seen = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st <= '{ctrl: prc_pkg::CTRL_RESET_VAL, amp: prc_pkg::AMP_RESET_VAL, default: '0};
      end else begin
         st <= next_st;
      end
   end

   // Reset and sleep pass straight through, no ordering needed
   assign lnk.supply_good_input = st.pg;
   assign lnk.chip_reset_input_n = st.ctrl[prc_pkg::CTRL_RST_N];
   assign lnk.chip_sleep_input = st.ctrl[prc_pkg::CTRL_SLEEP];
   assign lnk.link_pd_ind = st.ctrl[prc_pkg::CTRL_PD];
   assign lnk.link_rx_amp = st.amp;
   assign prdata = st.rdata;
   assign pready = st.rdy;
   assign pslverr = st.err;
endmodule // prc_host
`default_nettype wire

/* File: prc_props.sv */
// Interface checks on supply good and the host clock between the two ends
`timescale 1ns/1ps
`default_nettype none
module prc_props #(
   parameter int PG_LOW_CYC = prc_pkg::PG_LOW_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic supply_good_input,
   input wire logic chip_reset_input_n,
   input wire logic chip_sleep_input,
   input wire logic link_pd_ind,
   input wire logic [7:0] link_rx_amp,
   input wire logic host_clock_output
);
   typedef struct packed {
      logic [15:0] hi;
      logic [15:0] lo;
   } prc_chk_t;
   prc_chk_t st, next_st;
   // Run lengths of supply good high and low, saturating so they never wrap
   always_comb begin
      next_st = st;
      next_st.hi = 16'h0;
      next_st.lo = 16'h0;
      if (supply_good_input) next_st.hi = (st.hi == 16'hFFFF) ? st.hi : st.hi + 16'h1;
      else next_st.lo = (st.lo == 16'hFFFF) ? st.lo : st.lo + 16'h1;
   end
   always_ff @(posedge core_clk) begin
      if (rst) st <= '0;
      else st <= next_st;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Margin covers the two-flop synchroniser, the clock enable flop and the output flop
   sequence sg_gone;
      !supply_good_input [*5];
   endsequence
   sequence clk_moves;
      ##[1:2] $changed(host_clock_output);
   endsequence
   clk_start_a: assert property (st.hi > prc_pkg::CLK_START_CYC + 8 |-> ##[0:1] $changed(host_clock_output))
      else $error("host clock not running after supply good");
   clk_quiet_a: assert property (supply_good_input && st.hi < prc_pkg::CLK_START_CYC |-> !host_clock_output)
      else $error("host clock started too early");
   // Only while supply good stands: a supply drop may cut a half period short
   clk_div_a: assert property ($rose(host_clock_output) && supply_good_input |=>
      host_clock_output ##1 !host_clock_output)
      else $error("host clock half period wrong");
   clk_off_a: assert property (sg_gone |-> !host_clock_output)
      else $error("host clock runs without supply good");
   clk_in_reset_a: assert property (!chip_reset_input_n && st.hi > prc_pkg::CLK_START_CYC + 8 |-> clk_moves)
      else $error("host clock stopped in reset");
   clk_in_sleep_a: assert property (chip_sleep_input && st.hi > prc_pkg::CLK_START_CYC + 8 |-> clk_moves)
      else $error("host clock stopped in sleep");
   pg_low_pulse_a: assert property ($rose(supply_good_input) |-> st.lo >= PG_LOW_CYC)
      else $error("supply good low pulse too short");
   cover property (link_pd_ind && supply_good_input);
   cover property (link_rx_amp < prc_pkg::IDLE_ENTER_MV);
endmodule // prc_props
`default_nettype wire

/* File: tb.sv */
// Self-checking bench: hub end and PHY end joined over the control link
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int PGL = 20;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic supply_ok = 1'b0;
   logic osc_stable = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lps = 1'b0, lplu = 1'b0, an_dis = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, powered, lrst, active, idle, tx;
   logic [1:0] p_dis = 2'h0, p_pd = 2'h0, l_req = 2'h0, l_up = 2'h0, e_seen = 2'h0, f_en = 2'h0;
   logic [1:0] phy_en, lk_en, ed;
   logic [3:0] f_spd = 4'h0, pt_spd = 4'h0, spd;
   logic [7:0] amp_tab [4] = '{8'h41, 8'h40, 8'hC8, 8'hC9};
   int n_errors = 0, n_tests = 0, cyc = 0;
   prc_if lnk ();
   prc_host #(.PG_LOW_CYC(PGL)) prc_host_inst (.core_clk(core_clk), .rst(rst), .lnk(lnk.host),
      .supply_ok(supply_ok), .osc_stable(osc_stable), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   prc_device prc_device_inst (.core_clk(core_clk), .rst(rst), .lnk(lnk.device),
      .port_disable(p_dis), .phy_pd_bit(p_pd), .link_required(l_req), .link_up(l_up),
      .energy_seen(e_seen), .force_en(f_en), .force_speed(f_spd), .partner_speed(pt_spd),
      .low_power_state(lps), .low_power_link_up(lplu), .an1000_disable(an_dis),
      .chip_powered(powered), .logic_reset(lrst), .chip_active(active), .link_idle(idle),
      .tx_active(tx), .port_phy_en(phy_en), .port_link_en(lk_en), .energy_detect_mode(ed),
      .speed_sel(spd));
   prc_props #(.PG_LOW_CYC(PGL)) prc_props_inst (.core_clk(core_clk), .rst(rst),
      .supply_good_input(lnk.supply_good_input), .chip_reset_input_n(lnk.chip_reset_input_n),
      .chip_sleep_input(lnk.chip_sleep_input), .link_pd_ind(lnk.link_pd_ind),
      .link_rx_amp(lnk.link_rx_amp), .host_clock_output(lnk.host_clock_output));
   always #4 core_clk = ~core_clk;
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Bounded wait for supply good to reach a level
   task automatic wait_sg(input logic v);
      int k = 0;
      while (lnk.supply_good_input !== v && k < 100) begin
         tick(1);
         k++;
      end
      chk("supply_good", {31'h0, v}, {31'h0, lnk.supply_good_input});
   endtask
   // Host clock edges in 8 cycles: 4 when running at the divided rate
   task automatic clk_edges(input int e);
      int c = 0;
      logic h;
      repeat (8) begin
         h = lnk.host_clock_output;
         tick(1);
         if (lnk.host_clock_output !== h) c++;
      end
      chk("clk_edges", e, c);
   endtask
   // Speed expected from force, partner value and power-state caps
   function automatic logic [1:0] exp_spd(logic fe, logic [1:0] fs, logic [1:0] ps);
      logic [1:0] s;
      s = fe ? fs : ps;
      if (lps && lplu) s = prc_pkg::SPD_10;
      else if ((lps || an_dis) && s == prc_pkg::SPD_1000) s = prc_pkg::SPD_100;
      return s;
   endfunction
   task automatic results;
      $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Hang guard well above the longest expected run
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         results();
      end
   end
   initial begin
      tick(20);
      rst <= 1'b0;
      apb(1'b0, prc_pkg::REG_CTRL, 32'h0);
      chk("ctrl_reset", 32'h0, rd);
      apb(1'b0, prc_pkg::REG_AMP, 32'h0);
      chk("amp_reset", 32'hFF, rd);
      apb(1'b0, 8'h0C, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, err});
      apb(1'b1, prc_pkg::REG_CTRL, 32'h3);
      tick(PGL * 2);
      chk("pg_no_supply", 32'h0, {31'h0, lnk.supply_good_input});
      supply_ok <= 1'b1;
      tick(PGL * 2);
      chk("pg_no_osc", 32'h0, {31'h0, lnk.supply_good_input});
      osc_stable <= 1'b1;
      tick(PGL - 2);
      chk("pg_hold", 32'h0, {31'h0, lnk.supply_good_input});
      wait_sg(1'b1);
      clk_edges(0);
      tick(prc_pkg::CLK_START_CYC + 8);
      clk_edges(4);
      apb(1'b0, prc_pkg::REG_STATUS, 32'h0);
      chk("status_on", 32'h3, rd);
      $display("power-up test done");
      // Mode table over reset and sleep with supply good high
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, prc_pkg::REG_CTRL, {29'h0, i[1], i[0], 1'b1});
         tick(8);
         chk("logic_reset", {31'h0, ~i[0]}, {31'h0, lrst});
         chk("active", {31'h0, i[0] & ~i[1]}, {31'h0, active});
         chk("powered", 32'h1, {31'h0, powered});
         clk_edges(4);
      end
      $display("mode test done");
      apb(1'b1, prc_pkg::REG_CTRL, 32'h3);
      f_en <= 2'h1;
      pt_spd <= 4'h9;
      for (int i = 0; i < 16; i++) begin
         lps <= i[0];
         lplu <= i[1];
         an_dis <= i[2];
         f_spd <= i[3] ? 4'h1 : 4'h2;
         tick(6);
         chk("speed", {28'h0, exp_spd(1'b0, f_spd[3:2], pt_spd[3:2]),
            exp_spd(1'b1, f_spd[1:0], pt_spd[1:0])}, {28'h0, spd});
      end
      $display("speed test done");
      p_dis <= 2'h2;
      p_pd <= 2'h1;
      l_req <= 2'h3;
      l_up <= 2'h0;
      tick(6);
      chk("phy_en_off", 32'h0, {30'h0, phy_en});
      chk("link_en", 32'h1, {30'h0, lk_en});
      chk("speed_off", 32'h0, {28'h0, spd & 4'hC});
      p_dis <= 2'h0;
      p_pd <= 2'h0;
      l_up <= 2'h1;
      tick(6);
      chk("energy_mode", 32'h2, {30'h0, ed});
      e_seen <= 2'h2;
      tick(6);
      chk("energy_found", 32'h0, {30'h0, ed});
      e_seen <= 2'h0;
      apb(1'b1, prc_pkg::REG_CTRL, 32'hB);
      tick(8);
      chk("pd_ind", 32'h0, {30'h0, phy_en});
      chk("pd_tx", 32'h0, {31'h0, tx});
      apb(1'b1, prc_pkg::REG_CTRL, 32'h3);
      $display("port test done");
      // Idle entry needs amplitude under 65 held, exit needs above 200
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, prc_pkg::REG_AMP, {24'h0, amp_tab[i]});
         tick(14);
         chk("link_idle", {31'h0, i == 1 || i == 2}, {31'h0, idle});
         chk("tx_active", {31'h0, i == 0 || i == 3}, {31'h0, tx});
      end
      $display("idle test done");
      apb(1'b1, prc_pkg::REG_CTRL, 32'h2);
      wait_sg(1'b0);
      tick(5);
      chk("off_powered", 32'h0, {31'h0, powered});
      chk("off_reset", 32'h1, {31'h0, lrst});
      clk_edges(0);
      apb(1'b0, prc_pkg::REG_STATUS, 32'h0);
      chk("status_off", 32'h0, rd);
      apb(1'b1, prc_pkg::REG_CTRL, 32'h3);
      wait_sg(1'b1);
      tick(6);
      chk("reactive", 32'h1, {31'h0, active});
      $display("power-off test done");
      results();
   end
endmodule // tb
`default_nettype wire
